//--- design/wdt_pkg.sv
// constants shared by the watchdog timer with write guard
package wdt_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int PRE_W  = 13;
  localparam int CNT_W  = 8;
  localparam int SEL_W  = 4;
  localparam int DIV_CYCLES = 8192; // prescaler division for the watchdog tick

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [ADDR_W-1:0] OFS_CONTROL_STATUS = 16'hffc0;
  localparam logic [ADDR_W-1:0] OFS_COUNTER        = 16'hffc1;
  localparam logic [ADDR_W-1:0] OFS_CLOCK_MODE     = 16'hffc2;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS     = 16'hffc3;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK       = 16'hffc4;

  // ************************************************************
  // control/status field positions
  // ************************************************************
  localparam int BIT_COUNTER_ENABLE_GUARD = 7;
  localparam int BIT_COUNTER_WRITE_ENABLE = 6;
  localparam int BIT_CONTROL_ENABLE_GUARD = 5;
  localparam int BIT_CONTROL_WRITE_ENABLE = 4;
  localparam int BIT_TIMER_ON_GUARD       = 3;
  localparam int BIT_TIMER_ON             = 2;
  localparam int BIT_RESET_FLAG_GUARD     = 1;
  localparam int BIT_OVERFLOW_RESET_FLAG  = 0;

  // ************************************************************
  // interrupt status bits
  // ************************************************************
  localparam int IRQ_W          = 2;
  localparam int IRQ_BIT_OVF    = 0; // counter overflow
  localparam int IRQ_BIT_REFUSE = 1; // counter write refused

  // ************************************************************
  // values after reset and encodings
  // ************************************************************
  localparam logic [CNT_W-1:0]  RST_COUNTER    = 8'h00;
  localparam logic [SEL_W-1:0]  RST_CLOCK_SEL  = 4'hf;
  localparam logic [SEL_W-1:0]  SEL_DIV8192    = 4'hf;
  localparam logic [IRQ_W-1:0]  RST_IRQ_MASK   = 2'h0;
  localparam logic [DATA_W-1:0] MODE_UPPER_RD  = 8'hf0; // unused mode bits read one
  localparam logic [DATA_W-1:0] GUARD_RD       = 8'haa; // guard bits read one
  localparam logic [DATA_W-1:0] UNMAPPED_RD    = 8'h00;

endpackage : wdt_pkg

//--- design/wdt_prescaler.sv
// free-running prescaler and tick selection for the watchdog counter
`timescale 1ns/1ps
module wdt_prescaler #(
  parameter int PRE_W = wdt_pkg::PRE_W
) (
  input  wire logic                     core_clk,
  input  wire logic                     rst_b,
  input  wire logic [wdt_pkg::SEL_W-1:0] clock_sel,
  output logic                          tick
);
  import wdt_pkg::*;

  // refuse at elaboration the widths that the tap mask cannot serve
  if (PRE_W < 2 || PRE_W > 16) begin : g_bad_width
    $error("prescaler width out of range");
  end

  logic [PRE_W-1:0] count;
  logic [PRE_W-1:0] tap_mask;
  logic [PRE_W-1:0] next_count;

  // select 0xf or any value past the top tap takes the full chain
  function automatic logic [PRE_W-1:0] sel_mask(input logic [SEL_W-1:0] sel);
    logic [PRE_W-1:0] m;
    m = '1;
    if (32'(sel) < PRE_W - 1) begin
      m = PRE_W'((32'd2 << sel) - 32'd1);
    end
    return m;
  endfunction

  assign tap_mask   = sel_mask(clock_sel);
  assign next_count = count + PRE_W'(1);

  // count every clock cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // tick on the last prescaler state of the selected period
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick <= 1'b0;
    end else begin
      tick <= ((next_count & tap_mask) == tap_mask);
    end
  end

  property p_pre_inc;
    @(posedge core_clk) disable iff (!rst_b)
    1'b1 |=> (count == $past(count) + PRE_W'(1));
  endproperty
  a_pre_inc: assert property (p_pre_inc) else $error("prescaler did not advance");

  property p_full_div;
    @(posedge core_clk) disable iff (!rst_b)
    (clock_sel == SEL_DIV8192 && count == '1) |-> tick;
  endproperty
  a_full_div: assert property (p_full_div) else $error("no tick at full division");

endmodule // wdt_prescaler

//--- design/wdt_top.sv
// watchdog timer with guarded control/status register and register port
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
module wdt_top (
  input  wire logic                       core_clk,
  input  wire logic                       rst_b,
  input  wire logic [wdt_pkg::ADDR_W-1:0] addr,
  input  wire logic [wdt_pkg::DATA_W-1:0] wr_data,
  input  wire logic                       wr_en,
  input  wire logic                       rd_en,
  output logic      [wdt_pkg::DATA_W-1:0] rd_data,
  output logic                            wdt_reset,
  output logic                            irq
);
  import wdt_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  logic [CNT_W-1:0] counter;
  logic             counter_write_enable;
  logic             control_write_enable;
  logic             timer_on;
  logic             overflow_reset_flag;
  logic [SEL_W-1:0] clock_sel;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;

  // ************************************************************
  // decode
  // ************************************************************
  wire sel_ctl   = (addr == OFS_CONTROL_STATUS);
  wire sel_cnt   = (addr == OFS_COUNTER);
  wire sel_mode  = (addr == OFS_CLOCK_MODE);
  wire sel_ists  = (addr == OFS_IRQ_STATUS);
  wire sel_imask = (addr == OFS_IRQ_MASK);

  wire wr_ctl   = wr_en & sel_ctl;
  wire wr_cnt   = wr_en & sel_cnt;
  wire wr_mode  = wr_en & sel_mode;
  wire wr_imask = wr_en & sel_imask;
  wire rd_ists  = rd_en & sel_ists;

  // guard bits come from the data of the same write
  wire take_cwe  = wr_ctl & ~wr_data[BIT_COUNTER_ENABLE_GUARD];
  wire take_ctwe = wr_ctl & ~wr_data[BIT_CONTROL_ENABLE_GUARD];
  wire take_on   = wr_ctl & control_write_enable
                 & ~wr_data[BIT_TIMER_ON_GUARD];
  wire take_flag = wr_ctl & control_write_enable
                 & ~wr_data[BIT_RESET_FLAG_GUARD];

  // counter write accepted only with its enable set
  wire cnt_load   = wr_cnt & counter_write_enable;
  wire cnt_refuse = wr_cnt & ~counter_write_enable;

  // ************************************************************
  // tick and overflow
  // ************************************************************
  logic tick;

  wdt_prescaler #(
    .PRE_W (PRE_W)
  ) u_prescaler (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .clock_sel (clock_sel),
    .tick      (tick)
  );

  wire cnt_step = tick & timer_on;
  wire overflow = cnt_step & ~cnt_load & (counter == '1);
  wire [CNT_W-1:0] next_counter = cnt_load ? wr_data[CNT_W-1:0]
                                : cnt_step ? counter + CNT_W'(1)
                                : counter;

  // ************************************************************
  // counter
  // ************************************************************
  // a software load wins over a tick in the same cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      counter <= RST_COUNTER;
    end else begin
      counter <= next_counter;
    end
  end

  // ************************************************************
  // control/status bits
  // ************************************************************
  // write enables follow their own guards
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      counter_write_enable <= 1'b0;
      control_write_enable <= 1'b0;
    end else begin
      if (take_cwe) begin
        counter_write_enable <= wr_data[BIT_COUNTER_WRITE_ENABLE];
      end
      if (take_ctwe) begin
        control_write_enable <= wr_data[BIT_CONTROL_WRITE_ENABLE];
      end
    end
  end

  // timer on and the reset flag need control enable as well
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_on            <= 1'b0;
      overflow_reset_flag <= 1'b0;
    end else begin
      if (take_on) begin
        timer_on <= wr_data[BIT_TIMER_ON];
      end
      if (overflow) begin
        overflow_reset_flag <= 1'b1;
      end else if (take_flag) begin
        overflow_reset_flag <= wr_data[BIT_OVERFLOW_RESET_FLAG];
      end
    end
  end

  // clock select kept in the low nibble of the mode register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      clock_sel <= RST_CLOCK_SEL;
    end else if (wr_mode) begin
      clock_sel <= wr_data[SEL_W-1:0];
    end
  end

  // ************************************************************
  // internal reset
  // ************************************************************
  // one-cycle reset request on overflow
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wdt_reset <= 1'b0;
    end else begin
      wdt_reset <= overflow;
    end
  end

  // ************************************************************
  // interrupts
  // ************************************************************
  wire [IRQ_W-1:0] irq_events = {cnt_refuse, overflow};
  wire [IRQ_W-1:0] next_irq_status = (rd_ists ? '0 : irq_status) | irq_events;

  // sticky status, cleared by reading it; a new event wins
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_status <= '0;
      irq_mask   <= RST_IRQ_MASK;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      if (wr_imask) begin
        irq_mask <= wr_data[IRQ_W-1:0];
      end
      irq <= |(next_irq_status & (wr_imask ? wr_data[IRQ_W-1:0] : irq_mask));
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  wire [DATA_W-1:0] ctl_view = GUARD_RD
    | (DATA_W'(counter_write_enable) << BIT_COUNTER_WRITE_ENABLE)
    | (DATA_W'(control_write_enable) << BIT_CONTROL_WRITE_ENABLE)
    | (DATA_W'(timer_on) << BIT_TIMER_ON)
    | (DATA_W'(overflow_reset_flag) << BIT_OVERFLOW_RESET_FLAG);

  wire [DATA_W-1:0] rd_mux = sel_ctl   ? ctl_view
                           : sel_cnt   ? DATA_W'(counter)
                           : sel_mode  ? (MODE_UPPER_RD | DATA_W'(clock_sel))
                           : sel_ists  ? DATA_W'(irq_status)
                           : sel_imask ? DATA_W'(irq_mask)
                           : UNMAPPED_RD;

  // read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= rd_mux;
    end else begin
      rd_data <= '0;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_ctl_write(int b);
    wr_ctl && wr_data[b];
  endsequence

  sequence s_overflow;
    timer_on && tick && counter == '1 && !cnt_load;
  endsequence

  sequence s_reset_out;
    wdt_reset && overflow_reset_flag;
  endsequence

  property p_cwe_guard;
    s_ctl_write(BIT_COUNTER_ENABLE_GUARD) |=> $stable(counter_write_enable);
  endproperty
  a_cwe_guard: assert property (p_cwe_guard) else $error("counter enable changed");

  property p_cwe_take;
    (wr_ctl && !wr_data[BIT_COUNTER_ENABLE_GUARD])
      |=> counter_write_enable == $past(wr_data[BIT_COUNTER_WRITE_ENABLE]);
  endproperty
  a_cwe_take: assert property (p_cwe_take) else $error("counter enable not taken");

  property p_cnt_load;
    (wr_cnt && counter_write_enable) |=> counter == $past(wr_data);
  endproperty
  a_cnt_load: assert property (p_cnt_load) else $error("counter write lost");

  property p_cnt_refuse;
    (wr_cnt && !counter_write_enable && !timer_on) |=> $stable(counter);
  endproperty
  a_cnt_refuse: assert property (p_cnt_refuse) else $error("counter written");

  property p_ctwe_guard;
    s_ctl_write(BIT_CONTROL_ENABLE_GUARD) |=> $stable(control_write_enable);
  endproperty
  a_ctwe_guard: assert property (p_ctwe_guard) else $error("control enable changed");

  property p_on_locked;
    (!control_write_enable || (wr_ctl && wr_data[BIT_TIMER_ON_GUARD]))
      |=> $stable(timer_on);
  endproperty
  a_on_locked: assert property (p_on_locked) else $error("timer on changed");

  property p_flag_guard;
    (s_ctl_write(BIT_RESET_FLAG_GUARD) ##0 !overflow) |=> $stable(overflow_reset_flag);
  endproperty
  a_flag_guard: assert property (p_flag_guard) else $error("reset flag changed");

  property p_ovf_reset;
    s_overflow |=> s_reset_out ##1 !wdt_reset;
  endproperty
  a_ovf_reset: assert property (p_ovf_reset) else $error("overflow reset missing");

  property p_off_hold;
    (!timer_on && !cnt_load) |=> $stable(counter) && !wdt_reset;
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("counter moved while off");

  property p_tick_gap;
    (tick && clock_sel == SEL_DIV8192 && !wr_mode) |=> !tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");

  property p_step;
    (timer_on && tick && !cnt_load) |=> counter == $past(counter) + CNT_W'(1);
  endproperty
  a_step: assert property (p_step) else $error("counter did not step");

  // open guards must let the new value of the governed bit in
  property p_ctwe_take;
    (wr_ctl && !wr_data[BIT_CONTROL_ENABLE_GUARD])
      |=> control_write_enable == $past(wr_data[BIT_CONTROL_WRITE_ENABLE]);
  endproperty
  a_ctwe_take: assert property (p_ctwe_take) else $error("control enable not taken");

  property p_on_take;
    (wr_ctl && control_write_enable && !wr_data[BIT_TIMER_ON_GUARD])
      |=> timer_on == $past(wr_data[BIT_TIMER_ON]);
  endproperty
  a_on_take: assert property (p_on_take) else $error("timer on not taken");

  property p_flag_take;
    (wr_ctl && control_write_enable && !wr_data[BIT_RESET_FLAG_GUARD] && !overflow)
      |=> overflow_reset_flag == $past(wr_data[BIT_OVERFLOW_RESET_FLAG]);
  endproperty
  a_flag_take: assert property (p_flag_take) else $error("reset flag not taken");

  // clock select follows every mode write
  property p_mode_take;
    wr_mode |=> clock_sel == $past(wr_data[SEL_W-1:0]);
  endproperty
  a_mode_take: assert property (p_mode_take) else $error("clock select not taken");

  // read data drop back to zero outside the answer cycle
  property p_rd_stand;
    !rd_en |=> rd_data == '0;
  endproperty
  a_rd_stand: assert property (p_rd_stand) else $error("read data held too long");

  // a status read with no new event leaves nothing pending
  property p_irq_clear;
    (rd_ists && irq_events == '0) |=> irq_status == '0;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("status not cleared");

  property p_irq_level;
    |(irq_status & irq_mask) |-> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

endmodule // wdt_top

//--- bench/tb_wdt_top.sv
// self-checking testbench for the watchdog timer with write guard
`timescale 1ns/1ps
module tb_wdt_top;
  import wdt_pkg::*;

  // ************************************************************
  // clock, reset and register port
  // ************************************************************
  logic              core_clk;
  logic              rst_b;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data;
  logic              wr_en;
  logic              rd_en;
  logic [DATA_W-1:0] rd_data;
  logic              wdt_reset;
  logic              irq;
  int                errors;
  int                comparisons;
  int                cycles;

  wdt_top i_dut (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .addr      (addr),
    .wr_data   (wr_data),
    .wr_en     (wr_en),
    .rd_en     (rd_en),
    .rd_data   (rd_data),
    .wdt_reset (wdt_reset),
    .irq       (irq)
  );

  // 25 MHz clock
  always #20 core_clk = ~core_clk;

  // hang guard: the whole run needs about 50000 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      errors = errors + 1;
      stop_test();
    end
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge core_clk);
    wr_en   <= 1'b0;
  endtask

  // read data is taken in the cycle after the strobe
  task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge core_clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask

  task automatic rd_check(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] d;
    reg_rd(a, d);
    check(d, exp);
  endtask

  task automatic irq_after(input logic exp);
    repeat (2) @(posedge core_clk);
    #1;
    check({7'h00, irq}, {7'h00, exp});
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset_values();
    rd_check(OFS_CONTROL_STATUS, 8'haa);
    @(posedge core_clk);
    #1;
    check(rd_data, 8'h00);
    rd_check(OFS_COUNTER, 8'h00);
    rd_check(OFS_CLOCK_MODE, 8'hff);
    rd_check(OFS_IRQ_STATUS, 8'h00);
    rd_check(OFS_IRQ_MASK, 8'h00);
    rd_check(16'hffc5, 8'h00);
  endtask

  // counter writes refused while counter write enable is clear
  task automatic t_counter_refused();
    reg_wr(OFS_IRQ_MASK, 8'h03);
    reg_wr(OFS_COUNTER, 8'h33);
    irq_after(1'b1);
    rd_check(OFS_COUNTER, 8'h00);
    rd_check(OFS_IRQ_STATUS, 8'h02);
    irq_after(1'b0);
    reg_wr(OFS_IRQ_MASK, 8'h01);
    reg_wr(OFS_COUNTER, 8'h44);
    irq_after(1'b0);
    rd_check(OFS_IRQ_STATUS, 8'h02);
    rd_check(OFS_IRQ_STATUS, 8'h00);
  endtask

  // each guard in the same write data decides its governed bit
  task automatic t_guards();
    reg_wr(OFS_CONTROL_STATUS, 8'hfe);
    rd_check(OFS_CONTROL_STATUS, 8'haa);
    reg_wr(OFS_CONTROL_STATUS, 8'h5a);
    rd_check(OFS_CONTROL_STATUS, 8'hfa);
    reg_wr(OFS_CONTROL_STATUS, 8'hfc);
    rd_check(OFS_CONTROL_STATUS, 8'hfa);
    reg_wr(OFS_CONTROL_STATUS, 8'hf5);
    rd_check(OFS_CONTROL_STATUS, 8'hff);
    reg_wr(OFS_CONTROL_STATUS, 8'hfa);
    rd_check(OFS_CONTROL_STATUS, 8'hff);
    reg_wr(OFS_CONTROL_STATUS, 8'hf0);
    rd_check(OFS_CONTROL_STATUS, 8'hfa);
    reg_wr(OFS_CONTROL_STATUS, 8'hc0);
    rd_check(OFS_CONTROL_STATUS, 8'hea);
    reg_wr(OFS_CONTROL_STATUS, 8'hf5);
    rd_check(OFS_CONTROL_STATUS, 8'hea);
    reg_wr(OFS_CONTROL_STATUS, 8'h5a);
    rd_check(OFS_CONTROL_STATUS, 8'hfa);
  endtask

  // timer off: a loaded counter holds across a full tick period
  task automatic t_hold_off();
    int hits;
    hits = 0;
    reg_wr(OFS_COUNTER, 8'hfe);
    rd_check(OFS_COUNTER, 8'hfe);
    repeat (8200) begin
      @(posedge core_clk);
      #1;
      if (wdt_reset !== 1'b0) hits++;
    end
    check({7'h00, hits != 0}, 8'h00);
    rd_check(OFS_COUNTER, 8'hfe);
  endtask

  task automatic t_mode();
    reg_wr(OFS_CLOCK_MODE, 8'h00);
    rd_check(OFS_CLOCK_MODE, 8'hf0);
    reg_wr(OFS_CLOCK_MODE, 8'hff);
    rd_check(OFS_CLOCK_MODE, 8'hff);
  endtask

  // overflow period after a reload of 0xfe is two ticks of 8192 cycles
  task automatic t_overflow();
    int n;
    n = 0;
    reg_wr(OFS_CONTROL_STATUS, 8'hf4);
    rd_check(OFS_CONTROL_STATUS, 8'hfe);
    reg_wr(OFS_COUNTER, 8'hfd);
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (wdt_reset !== 1'b1 && n < 3 * DIV_CYCLES + 20);
    check({7'h00, wdt_reset}, 8'h01);
    reg_wr(OFS_COUNTER, 8'hfe);
    #1;
    check({7'h00, wdt_reset}, 8'h00);
    n = 2;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (wdt_reset !== 1'b1 && n < 20000);
    check(n[15:8], 8'h40);
    check(n[7:0], 8'h00);
    rd_check(OFS_CONTROL_STATUS, 8'hff);
    check({7'h00, irq}, 8'h01);
    rd_check(OFS_IRQ_STATUS, 8'h01);
    irq_after(1'b0);
  endtask

  // ************************************************************
  // verdict
  // ************************************************************
  task automatic stop_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    core_clk    = 1'b0;
    rst_b       = 1'b0;
    addr        = '0;
    wr_data     = '0;
    wr_en       = 1'b0;
    rd_en       = 1'b0;
    errors      = 0;
    comparisons = 0;
    cycles      = 0;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    t_reset_values();
    t_counter_refused();
    t_guards();
    t_hold_off();
    t_mode();
    t_overflow();
    stop_test();
  end
endmodule // tb_wdt_top
